// ### common/mpdt_map.svh
// Constants for the partition decoder and translation buffer
`ifndef MPDT_MAP_SVH
`define MPDT_MAP_SVH

// ==========================================================================
// Register offsets on the APB slave (byte addresses)
`define MPDT_OFF_CTRL     12'h000
`define MPDT_OFF_WR_TAG   12'h004
`define MPDT_OFF_WR_DATA  12'h008
`define MPDT_OFF_WR_CMD   12'h00C
`define MPDT_OFF_STATUS   12'h010
`define MPDT_OFF_MISS     12'h014

// ==========================================================================
// Partition boundaries, top two or three address bits
`define MPDT_PART_IO      3'b111
`define MPDT_PART_KERN    3'b110
`define MPDT_PART_KMMU_HI 2'b10

// ==========================================================================
// Field positions
`define MPDT_CTRL_TAG_LSB 0
`define MPDT_CTRL_EH_BIT  16
`define MPDT_CMD_GO_BIT   31
`define MPDT_PAGE_BITS    12
`define MPDT_BYPASS_BITS  29

// ==========================================================================
// Reset values
`define MPDT_CTRL_RST     32'h0000_0000
`define MPDT_WORD_RST     32'h0000_0000

`endif

// ### common/mpdt_pkg.sv
// Types shared by the partition decoder and translation buffer
package mpdt_pkg;

  // ========================================================================
  // Build-time sizes
  localparam int WAYS      = 16;
  localparam int ENTRIES   = 128;
  localparam int SETS      = ENTRIES / WAYS;
  localparam int SET_W     = $clog2(SETS);
  localparam int WAY_W     = $clog2(WAYS);
  localparam int TAG_W     = 8;
  localparam int FRAME_W   = 20;
  localparam int VPN_W     = 20;

  // ========================================================================
  // Partition of a virtual address
  typedef enum logic [1:0] {
    PART_USER = 2'b00,
    PART_KMMU = 2'b01,
    PART_KERN = 2'b10,
    PART_IO   = 2'b11
  } mpdt_part_e;

  // Kind of access
  typedef enum logic [1:0] {
    ACC_FETCH = 2'b00,
    ACC_LOAD  = 2'b01,
    ACC_STORE = 2'b10
  } mpdt_acc_e;

  // Fault outcome
  typedef enum logic [2:0] {
    FLT_NONE   = 3'b000,
    FLT_FAST   = 3'b001,
    FLT_DOUBLE = 3'b010,
    FLT_PERM   = 3'b011,
    FLT_SUPER  = 3'b100
  } mpdt_flt_e;

  // One translation entry
  typedef struct packed {
    logic [VPN_W-1:0]   virtual_page_number;
    logic [TAG_W-1:0]   process_tag;
    logic               global_flag;
    logic [FRAME_W-1:0] physical_frame_number;
    logic               cacheable;
    logic               readable;
    logic               writable;
    logic               executable;
  } mpdt_entry_s;

  // Request from a pipeline stage
  typedef struct packed {
    logic        valid;
    mpdt_acc_e   kind;
    logic        user_mode;
    logic        uncached_op;
    logic [31:0] virtual_addr;
  } mpdt_req_s;

  // Answer to a pipeline stage
  typedef struct packed {
    logic        valid;
    mpdt_flt_e   fault;
    logic        cacheable;
    logic [31:0] phys_addr;
  } mpdt_rsp_s;

endpackage

// ### logic/mpdt_top.sv
// Partition decoder and shared translation buffer with APB load port
// ==========================================================================
// Notes on behaviour
// - Top partition supervisor only, untranslated, uncached
// - Kernel partition supervisor only, untranslated, cached
// - Translated kernel partition supervisor only, entry cacheability
// - User partition translated, entry decides access
// - Untranslated address clears top three bits
// - High physical memory only via translation
// - Uncacheable data goes straight to interconnect
// - Bit 31 never selects cache bypass
// - Uncached load/store variants always bypass cache
// - One buffer serves fetch and data
// - Entry stored in software-chosen way
// - Sixteen ways, 128 entries by default
// - Page tag compared with upper 20 bits
// - Process tag compared with current identifier
// - Global flag ignores process tag
// - Frame number forms upper physical bits
// - Entry cacheable flag sets default cacheability
// - Loads need read permission
// - Stores need write permission
// - Fetches need execute permission
// - Physical address is frame plus offset
// - Miss double or fast, permission fault
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "mpdt_map.svh"

module mpdt_top
  import mpdt_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Fetch stage
  input  wire mpdt_req_s   fetch_req,
  output mpdt_rsp_s        fetch_rsp,
  // Load/store stage
  input  wire mpdt_req_s   data_req,
  output mpdt_rsp_s        data_rsp
);

  // ========================================================================
  // Storage
  mpdt_entry_s tlb_mem [SETS][WAYS];  // Entry RAM, set by way
  logic [31:0] ctrl_q;                // Process tag and handler flag
  logic [31:0] wr_tag_q;              // Staged tag word
  logic [31:0] wr_data_q;             // Staged data word
  logic [31:0] wr_cmd_q;              // Last word written to command, way/set in low bits
  logic [31:0] hit_cnt_q;             // Data lookups without a fault
  logic [31:0] miss_cnt_q;            // Data lookups that faulted
  logic        load_go;               // Command write strobe
  logic        apb_acc;               // Access phase
  logic [TAG_W-1:0] cur_tag;          // Current process identifier
  logic             eh_flag;          // Handler-active status

  assign apb_acc = psel && penable;
  assign load_go = apb_acc && pwrite && (paddr == `MPDT_OFF_WR_CMD) &&
                   pwdata[`MPDT_CMD_GO_BIT];
  assign cur_tag = ctrl_q[`MPDT_CTRL_TAG_LSB +: TAG_W];
  assign eh_flag = ctrl_q[`MPDT_CTRL_EH_BIT];

  // ========================================================================
  // Decode a virtual address into its partition
  function automatic mpdt_part_e part_of(input logic [31:0] va);
    if (va[31:29] == `MPDT_PART_IO) begin
      part_of = PART_IO;
    end else if (va[31:29] == `MPDT_PART_KERN) begin
      part_of = PART_KERN;
    end else if (va[31:30] == `MPDT_PART_KMMU_HI) begin
      part_of = PART_KMMU;
    end else begin
      part_of = PART_USER;
    end
  endfunction

  // ========================================================================
  // One full translation of a request, shared by both stages
  function automatic mpdt_rsp_s translate(input mpdt_req_s rq,
                                          input logic [TAG_W-1:0] tag,
                                          input logic eh);
    mpdt_part_e       pt;
    logic [SET_W-1:0] set;
    logic             hit;
    mpdt_entry_s      ent;
    mpdt_entry_s      cand;
    logic             allow;
    mpdt_rsp_s        r;
    pt    = part_of(rq.virtual_addr);
    set   = rq.virtual_addr[`MPDT_PAGE_BITS +: SET_W];
    hit   = 1'b0;
    ent   = '0;
    allow = 1'b0;
    r     = '0;
    r.valid = rq.valid;
    // Search every way of the indexed set
    for (int w = 0; w < WAYS; w++) begin
      cand = tlb_mem[set][w];
      if (cand.virtual_page_number == rq.virtual_addr[31 -: VPN_W] &&
          (cand.global_flag || cand.process_tag == tag)) begin
        hit = 1'b1;                   // Several hits are undefined, last wins
        ent = cand;
      end
    end
    case (rq.kind)
      ACC_LOAD:  allow = ent.readable;
      ACC_STORE: allow = ent.writable;
      ACC_FETCH: allow = ent.executable;
      default:   allow = 1'b0;
    endcase
    if (rq.user_mode && pt != PART_USER) begin
      r.fault = FLT_SUPER;
    end else if (pt == PART_IO || pt == PART_KERN) begin
      // Untranslated: only low physical memory is reachable
      r.phys_addr = {3'b000, rq.virtual_addr[`MPDT_BYPASS_BITS-1:0]};
      r.cacheable = (pt == PART_KERN);
    end else if (!hit) begin
      r.fault = eh ? FLT_DOUBLE : FLT_FAST;
    end else if (!allow) begin
      r.fault = FLT_PERM;
    end else begin
      r.phys_addr = {ent.physical_frame_number,
                     rq.virtual_addr[`MPDT_PAGE_BITS-1:0]};
      r.cacheable = ent.cacheable;
    end
    // Uncached variants and fetches never use the data cache
    if (rq.uncached_op || rq.kind == ACC_FETCH || r.fault != FLT_NONE) begin
      r.cacheable = 1'b0;
    end
    translate = r;
  endfunction

  // ========================================================================
  // Lookup results, registered so outputs come from flops
  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_rsp <= '0;
      data_rsp  <= '0;
    end else begin
      fetch_rsp <= translate(fetch_req, cur_tag, eh_flag);
      data_rsp  <= translate(data_req, cur_tag, eh_flag);
    end
  end

  // ========================================================================
  // Statistics visible to software
  always_ff @(posedge clk) begin
    if (rst) begin
      hit_cnt_q  <= `MPDT_WORD_RST;
      miss_cnt_q <= `MPDT_WORD_RST;
    end else if (data_rsp.valid) begin
      if (data_rsp.fault == FLT_NONE) begin
        hit_cnt_q <= hit_cnt_q + 32'h0000_0001;
      end else begin
        miss_cnt_q <= miss_cnt_q + 32'h0000_0001;
      end
    end
  end

  // ========================================================================
  // Entry RAM write; software names the way, hardware obeys
  always_ff @(posedge clk) begin
    if (load_go) begin
      tlb_mem[pwdata[WAY_W +: SET_W]][pwdata[WAY_W-1:0]] <= {
        wr_tag_q[31 -: VPN_W],
        wr_tag_q[TAG_W:1],
        wr_tag_q[0],
        wr_data_q[FRAME_W+3:4],
        wr_data_q[3:0]
      };
    end
  end
  // No reset of entries: software fills them with peripheral pages

  // ========================================================================
  // Control and staging registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q    <= `MPDT_CTRL_RST;
      wr_tag_q  <= `MPDT_WORD_RST;
      wr_data_q <= `MPDT_WORD_RST;
      wr_cmd_q  <= `MPDT_WORD_RST;
    end else if (apb_acc && pwrite) begin
      case (paddr)
        `MPDT_OFF_CTRL:    ctrl_q    <= pwdata;
        `MPDT_OFF_WR_TAG:  wr_tag_q  <= pwdata;
        `MPDT_OFF_WR_DATA: wr_data_q <= pwdata;
        `MPDT_OFF_WR_CMD:  wr_cmd_q  <= pwdata;
        default:           ;
      endcase
    end
  end

  // ========================================================================
  // APB answer: zero wait, error on unmapped word
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;  // Answer in first access cycle
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable) begin
        case (paddr)
          `MPDT_OFF_CTRL:    prdata <= ctrl_q;
          `MPDT_OFF_WR_TAG:  prdata <= wr_tag_q;
          `MPDT_OFF_WR_DATA: prdata <= wr_data_q;
          `MPDT_OFF_WR_CMD:  prdata <= wr_cmd_q;
          `MPDT_OFF_STATUS:  prdata <= hit_cnt_q;
          `MPDT_OFF_MISS:    prdata <= miss_cnt_q;
          default:           pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule

// ### testbench/mpdt_top_sva.sv
// Checker on the ports of the partition decoder and translation buffer
`timescale 1ns/100ps
module mpdt_top_sva
  import mpdt_pkg::*;
(
  // Clock, reset and APB
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pipeline stages
  input wire mpdt_req_s   fetch_req,
  input wire mpdt_rsp_s   fetch_rsp,
  input wire mpdt_req_s   data_req,
  input wire mpdt_rsp_s   data_rsp
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ========
  // Supervisor data access into one partition
  sequence sup_data(logic [2:0] top);
    data_req.valid && !data_req.user_mode && data_req.kind != ACC_FETCH
      && data_req.virtual_addr[31:29] == top;
  endsequence
  // Peripheral space: no translation, never cached
  io_bypass_a: assert property (sup_data(3'b111) |=> data_rsp.fault == FLT_NONE
    && !data_rsp.cacheable
    && data_rsp.phys_addr == {3'b000, $past(data_req.virtual_addr[28:0])})
    else $error("peripheral bypass wrong");
  kern_cache_a: assert property (sup_data(3'b110) ##0 !data_req.uncached_op
    |=> data_rsp.cacheable && data_rsp.phys_addr[31:29] == 3'b000)
    else $error("kernel bypass wrong");
  uncached_a: assert property (data_req.valid && data_req.uncached_op
    |=> !data_rsp.cacheable) else $error("uncached op cached");
  user_super_a: assert property (data_req.valid && data_req.user_mode
    && data_req.virtual_addr[31] |=> data_rsp.fault == FLT_SUPER)
    else $error("user data not blocked");
  fetch_super_a: assert property (fetch_req.valid && fetch_req.user_mode
    && fetch_req.virtual_addr[31] |=> fetch_rsp.fault == FLT_SUPER)
    else $error("user fetch not blocked");
  page_offset_a: assert property (data_req.valid |=> data_rsp.valid &&
    (data_rsp.fault != FLT_NONE
    || data_rsp.phys_addr[11:0] == $past(data_req.virtual_addr[11:0])))
    else $error("offset not kept");
  fault_zero_a: assert property (data_rsp.valid && data_rsp.fault != FLT_NONE
    |-> data_rsp.phys_addr == 32'h0000_0000) else $error("faulted address leaks");
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one pulse");
endmodule

bind mpdt_top mpdt_top_sva mpdt_top_sva_i (.clk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .fetch_req, .fetch_rsp, .data_req, .data_rsp);

// ### testbench/mpdt_pipe_model.sv
// Model of the fetch and load/store stages issuing lookups
`timescale 1ns/100ps
module mpdt_pipe_model
  import mpdt_pkg::*;
(
  // Clock
  input wire logic      clk,
  // Requests out, answers in
  output mpdt_req_s     fetch_req,
  output mpdt_req_s     data_req,
  input wire mpdt_rsp_s fetch_rsp,
  input wire mpdt_rsp_s data_rsp
);
  // Idle stages at time zero
  initial begin
    fetch_req = '0;
    data_req = '0;
  end
  // One lookup; the address is inverted once released so stale values never match
  task automatic look(input logic f, input mpdt_acc_e k, input logic u, input logic c,
                      input logic [31:0] va, output mpdt_rsp_s rsp);
    @(posedge clk);
    if (f) begin
      fetch_req <= '{1'b1, k, u, c, va};
    end else begin
      data_req <= '{1'b1, k, u, c, va};
    end
    @(posedge clk);
    fetch_req <= '{1'b0, ACC_FETCH, 1'b0, 1'b0, ~va};
    data_req <= '{1'b0, ACC_LOAD, 1'b0, 1'b0, ~va};
    #1;
    rsp = f ? fetch_rsp : data_rsp;
  endtask
endmodule

// ### testbench/mpdt_top_bench.sv
// Self-checking bench for the partition decoder and translation buffer
`timescale 1ns/100ps
module mpdt_top_bench;
  import mpdt_pkg::*;
  // Bus and stage signals
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  mpdt_req_s   fetch_req, data_req;
  mpdt_rsp_s   fetch_rsp, data_rsp, r;
  int          bad_count, check_count;

  mpdt_top mpdt_top_i (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fetch_req, .fetch_rsp, .data_req, .data_rsp);
  mpdt_pipe_model mpdt_pipe_model_i (.clk, .fetch_req, .data_req, .fetch_rsp, .data_rsp);

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ========
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; bounded wait for ready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    if (pready !== 1'b1) begin
      bad_count++;
      report_and_stop;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Entry load: slot is set then way, as software picks it
  task automatic load(input logic [31:0] t, input logic [31:0] d, input logic [6:0] s);
    apb(1'b1, 12'h004, t);
    apb(1'b1, 12'h008, d);
    apb(1'b1, 12'h00C, {1'b1, 24'h00_0000, s});
  endtask
  task automatic lk(input logic f, input mpdt_acc_e k, input logic u, input logic c,
    input logic [31:0] va, input mpdt_flt_e ef, input logic ec, input logic [31:0] ep);
    mpdt_pipe_model_i.look(f, k, u, c, va, r);
    chk(32'({r.valid, r.fault, r.cacheable}), 32'({1'b1, ef, ec}));
    chk(r.phys_addr, ep);
  endtask
  // ========
  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    $display("t_regs done");
  endtask
  // Unique peripheral page numbers never hit, so this clears all entries
  task automatic t_flush;
    for (int i = 0; i < 128; i++) begin
      load({20'hE0000 | 20'(i), 12'h000}, 32'h0000_0000, 7'(i));
    end
    lk(0, ACC_LOAD, 1, 0, 32'h0000_3ABC, FLT_FAST, 0, 0);
    apb(1'b1, 12'h000, 32'h0001_0000);
    lk(0, ACC_LOAD, 0, 0, 32'h8000_5000, FLT_DOUBLE, 0, 0);
    $display("t_flush done");
  endtask
  task automatic t_bypass;
    apb(1'b1, 12'h000, 32'h0000_0005);
    lk(0, ACC_LOAD, 0, 0, 32'hE123_4567, FLT_NONE, 0, 32'h0123_4567);
    lk(0, ACC_STORE, 0, 0, 32'hDEAD_BEEF, FLT_NONE, 1, 32'h1EAD_BEEF);
    lk(0, ACC_LOAD, 0, 1, 32'hC000_0010, FLT_NONE, 0, 32'h0000_0010);
    lk(1, ACC_FETCH, 0, 0, 32'hC000_0100, FLT_NONE, 0, 32'h0000_0100);
    lk(0, ACC_LOAD, 1, 0, 32'hE000_0000, FLT_SUPER, 0, 0);
    lk(0, ACC_STORE, 1, 0, 32'h8000_0000, FLT_SUPER, 0, 0);
    lk(1, ACC_FETCH, 1, 0, 32'hC000_0000, FLT_SUPER, 0, 0);
    $display("t_bypass done");
  endtask
  task automatic t_hit;
    load(32'h0000_300A, 32'h0012_345D, 7'h35);
    lk(0, ACC_LOAD, 1, 0, 32'h0000_3ABC, FLT_NONE, 1, 32'h1234_5ABC);
    lk(0, ACC_STORE, 1, 0, 32'h0000_3ABC, FLT_PERM, 0, 0);
    lk(0, ACC_LOAD, 1, 1, 32'h0000_3ABC, FLT_NONE, 0, 32'h1234_5ABC);
    lk(1, ACC_FETCH, 1, 0, 32'h0000_3FFC, FLT_NONE, 0, 32'h1234_5FFC);
    lk(0, ACC_LOAD, 1, 0, 32'h0001_3ABC, FLT_FAST, 0, 0);
    load(32'h0000_4013, 32'h00AB_CDE6, 7'h4F);
    lk(0, ACC_STORE, 1, 0, 32'h0000_4008, FLT_NONE, 0, 32'hABCD_E008);
    lk(1, ACC_FETCH, 0, 0, 32'h0000_4008, FLT_PERM, 0, 0);
    load(32'h8000_2001, 32'h00F0_001C, 7'h20);
    lk(0, ACC_LOAD, 0, 0, 32'h8000_2344, FLT_NONE, 1, 32'hF000_1344);
    apb(1'b1, 12'h000, 32'h0000_0006);
    lk(0, ACC_LOAD, 1, 0, 32'h0000_3ABC, FLT_FAST, 0, 0);
    // Data lookups so far: seven without a fault, seven faulted
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(rd, 32'h0000_0007);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk(rd, 32'h0000_0007);
    $display("t_hit done");
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_flush;
    t_bypass;
    t_hit;
    report_and_stop;
  end
endmodule
